// [uar_pkg.sv]
package uar_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [3:0] FLAG_REGISTER_ADDR        = 4'h0;
  localparam logic [3:0] DATA_PORT_REGISTER_ADDR   = 4'h4;
  localparam logic [3:0] DIVIDER_HIGH_REGISTER_ADDR = 4'h8;
  localparam logic [3:0] DIVIDER_LOW_REGISTER_ADDR = 4'hC;

  // ****************************************************************
  // Control and flag field positions
  // ****************************************************************
  localparam int CTL_RX_ENABLE_BIT   = 0;
  localparam int CTL_WORD9_BIT       = 1;
  localparam int CTL_RX_IRQ_EN_BIT   = 2;
  localparam int CTL_IDLE_IRQ_EN_BIT = 3;
  localparam int CTL_TWO_STOP_BIT    = 4;
  localparam int CTL_NINTH_BIT       = 8;
  localparam int FLG_FRAMING_BIT     = 1;
  localparam int FLG_NOISE_BIT       = 2;
  localparam int FLG_OVERRUN_BIT     = 3;
  localparam int FLG_IDLE_BIT        = 4;
  localparam int FLG_FULL_BIT        = 5;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [15:0] DIVIDER_RESET   = 16'h0010;
  localparam logic [15:0] DIVIDER_MIN     = 16'h0010;
  localparam logic [3:0]  OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0]  SAMPLE_A        = 4'h7;
  localparam logic [3:0]  SAMPLE_B        = 4'h8;
  localparam logic [3:0]  SAMPLE_C        = 4'h9;
  localparam logic [3:0]  START_S3        = 4'h2;
  localparam logic [3:0]  START_S5        = 4'h4;
  localparam logic [3:0]  START_S7        = 4'h6;
  localparam logic [3:0]  DATA_BITS_8     = 4'h8;
  localparam logic [3:0]  DATA_BITS_9     = 4'h9;

  typedef enum logic [2:0] {
    UAR_IDLE  = 3'b000,
    UAR_START = 3'b001,
    UAR_DATA  = 3'b010,
    UAR_STOP  = 3'b011
  } uar_state_type;

endpackage : uar_pkg

// [uar_receiver.sv]
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Start needs samples high, high, then low.
// - Broken start pattern returns idle, no flag.
// - Two of three low accepts start, noisy.
// - Clean start needs samples 3, 5, 7 and 8-10 all low.
// - Data shifted in least significant first.
// - Receiver enable starts hunting for start.
// - Completion loads holding buffer, sets full.
// - Data read or zero write clears full.
// - Disabling receiver aborts current character.
// - Break reported as framing fault.
// - Idle frame acts as character plus interrupt.
// - Completion while full sets overrun, interrupts.
// - Overrun keeps buffer, discards new character.
// - Overrun clears by flag then data read.
// - Input sampled at sixteen times baud.
// - Bit is majority of three, mixed noisy.
// - Noise rises with full, data still loaded.
// - Noise clears by flag then data read.
// - Missing stop sets framing, data still loaded.
// - Framing has no own interrupt, clears likewise.
// - Nine-bit mode keeps top bit separately.
// - Single stop checked on samples 8-10.
module uar_receiver
  import uar_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  // Serial line
  input  wire logic        rx_line_i,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Interrupt request
  output logic             rx_irq_o
);
  import uar_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0]   divider;
  logic [7:0]    divider_low_shadow;
  logic          receiver_enable;
  logic          word_nine;
  logic          receive_irq_enable;
  logic          idle_line_irq_enable;
  logic          two_stop;
  logic          ninth_received_bit;
  logic [7:0]    receive_holding_buffer;
  logic          receive_full_flag;
  logic          noise_flag;
  logic          framing_flag;
  logic          overrun_flag;
  logic          idle_flag;
  logic          flag_read_armed;
  logic          ack;

  // Bus request and its decode
  logic          acc;
  logic          commit;
  logic          wr_hit;
  logic          rd_data;
  logic          rd_flag;
  assign acc     = (avs_read_i | avs_write_i) & clk_en_i & ~ack;
  // Side effects land on the answer edge; read data is captured one earlier
  assign commit  = (avs_read_i | avs_write_i) & clk_en_i & ack;
  assign wr_hit  = commit & avs_write_i & avs_byteenable_i[0];
  assign rd_data = commit & avs_read_i
                 & (avs_address_i == DATA_PORT_REGISTER_ADDR);
  assign rd_flag = commit & avs_read_i
                 & (avs_address_i == FLAG_REGISTER_ADDR);

  function automatic logic wr_to(input logic [3:0] a);
    wr_to = wr_hit & (avs_address_i == a);
  endfunction : wr_to

  // One wait state, answer on the second edge
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      ack <= 1'b0;
    else if (clk_en_i)
      ack <= acc;
  end

  // ****************************************************************
  // Oversampling tick
  // ****************************************************************
  logic [15:0] tick_cnt;
  logic        tick;
  assign tick = clk_en_i & (tick_cnt == 16'h0000);

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      tick_cnt <= 16'h0000;
    else if (clk_en_i)
    begin
      // Divider is clocks per bit; one tick every sixteenth of it
      if (tick_cnt == 16'h0000)
        tick_cnt <= (divider < DIVIDER_MIN) ? 16'h0000
                                            : 16'(divider[15:4] - 12'h001);
      else
        tick_cnt <= tick_cnt - 16'h0001;
    end
  end

  // ****************************************************************
  // Receive state machine
  // ****************************************************************
  uar_state_type state;
  logic [3:0]    phase;
  logic [3:0]    bit_idx;
  logic [2:0]    votes;
  logic [8:0]    shift;
  logic          line_d1;
  logic          line_d2;
  logic          frame_noise;
  logic          all_ones;
  logic          done;
  logic          done_frame_err;
  logic          vote_bit;
  logic          vote_noisy;

  // Majority of three, mixed patterns flagged
  assign vote_bit   = (votes[0] & votes[1]) | (votes[1] & votes[2])
                    | (votes[0] & votes[2]);
  assign vote_noisy = (votes != 3'b000) & (votes != 3'b111);

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state          <= UAR_IDLE;
      phase          <= 4'h0;
      bit_idx        <= 4'h0;
      votes          <= 3'b000;
      shift          <= 9'h000;
      line_d1        <= 1'b1;
      line_d2        <= 1'b1;
      frame_noise    <= 1'b0;
      all_ones       <= 1'b0;
      done           <= 1'b0;
      done_frame_err <= 1'b0;
    end
    else if (clk_en_i)
    begin
      done <= 1'b0;
      if (!receiver_enable)
        state <= UAR_IDLE;
      else if (tick)
      begin
        line_d1 <= rx_line_i;
        line_d2 <= line_d1;
        unique case (state)
          UAR_IDLE:
          begin
            // Two highs then a low
            if (line_d2 & line_d1 & ~rx_line_i)
            begin
              state       <= UAR_START;
              phase       <= 4'h1;
              frame_noise <= 1'b0;
            end
          end
          UAR_START:
          begin
            phase <= phase + 4'h1;
            if (phase == START_S3 || phase == SAMPLE_A)
              votes <= {2'b00, rx_line_i};
            else if (phase == START_S5 || phase == START_S7 ||
                     phase == SAMPLE_B || phase == SAMPLE_C)
              votes <= {votes[1:0], rx_line_i};
            if (phase == START_S7 + 4'h1 || phase == SAMPLE_C + 4'h1)
            begin
              // Need at least two lows of three
              if (vote_bit)
                state <= UAR_IDLE;
              else
              begin
                frame_noise <= frame_noise | vote_noisy;
                if (phase == SAMPLE_C + 4'h1)
                begin
                  state    <= UAR_DATA;
                  bit_idx  <= 4'h0;
                  all_ones <= 1'b0;
                end
              end
            end
            if (phase == OVERSAMPLE_LAST)
              phase <= 4'h0;
          end
          UAR_DATA, UAR_STOP:
          begin
            phase <= phase + 4'h1;
            if (phase == SAMPLE_A)
              votes <= {2'b00, rx_line_i};
            else if (phase == SAMPLE_B || phase == SAMPLE_C)
              votes <= {votes[1:0], rx_line_i};
            if (phase == SAMPLE_C + 4'h1)
            begin
              frame_noise <= frame_noise | vote_noisy;
              if (state == UAR_DATA)
              begin
                // LSB first; 9-bit frames fill bit 8
                if (word_nine)
                  shift <= {vote_bit, shift[8:1]};
                else
                  shift <= {1'b0, vote_bit, shift[7:1]};
                all_ones <= (bit_idx == 4'h0) ? vote_bit
                                              : (all_ones & vote_bit);
                bit_idx <= bit_idx + 4'h1;
                if (bit_idx == (word_nine ? DATA_BITS_9 : DATA_BITS_8)
                               - 4'h1)
                  state <= UAR_STOP;
              end
              else
              begin
                // Second stop bit never checked; break lands here
                done           <= 1'b1;
                done_frame_err <= ~vote_bit;
                frame_noise    <= frame_noise | vote_noisy;
                state          <= UAR_IDLE;
              end
            end
          end
          default: state <= UAR_IDLE;
        endcase
      end
    end
  end

  // Idle frame: start bit never seen, so detect a frame of line-high
  logic [7:0] idle_cnt;
  logic       idle_seen;
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      idle_cnt  <= 8'h00;
      idle_seen <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (!receiver_enable || state != UAR_IDLE || !line_d1)
        idle_cnt <= 8'h00;
      else if (tick && idle_cnt != 8'hFF)
        idle_cnt <= idle_cnt + 8'h01;
      // One pulse per idle stretch of a full frame
      idle_seen <= tick && receiver_enable && idle_cnt ==
                   (word_nine ? 8'hB0 : 8'hA0);
    end
  end

  // ****************************************************************
  // Status flags and holding buffer
  // ****************************************************************
  logic load;
  logic err_clear;
  assign load      = done & ~receive_full_flag;
  // Flag read arms, data read clears
  assign err_clear = rd_data & flag_read_armed;

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      receive_holding_buffer <= 8'h00;
      ninth_received_bit     <= 1'b0;
      receive_full_flag      <= 1'b0;
      noise_flag             <= 1'b0;
      framing_flag           <= 1'b0;
      overrun_flag           <= 1'b0;
      idle_flag              <= 1'b0;
      flag_read_armed        <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (rd_flag)
        flag_read_armed <= 1'b1;
      else if (rd_data)
        flag_read_armed <= 1'b0;
      // Old byte kept during overrun
      if (load)
      begin
        receive_holding_buffer <= shift[7:0];
        ninth_received_bit     <= shift[8];
      end
      // Set wins over clear
      if (load || idle_seen)
        receive_full_flag <= 1'b1;
      else if (rd_data || (wr_to(FLAG_REGISTER_ADDR) &&
               !avs_writedata_i[FLG_FULL_BIT]))
        receive_full_flag <= 1'b0;
      if (done & receive_full_flag)
        overrun_flag <= 1'b1;
      else if (err_clear)
        overrun_flag <= 1'b0;
      if (load & frame_noise)
        noise_flag <= 1'b1;
      else if (err_clear)
        noise_flag <= 1'b0;
      if (load & done_frame_err)
        framing_flag <= 1'b1;
      else if (err_clear)
        framing_flag <= 1'b0;
      if (idle_seen)
        idle_flag <= 1'b1;
      else if (err_clear)
        idle_flag <= 1'b0;
    end
  end

  // Framing has no interrupt of its own
  assign rx_irq_o = (receive_irq_enable & (receive_full_flag | overrun_flag))
                  | (idle_line_irq_enable & idle_flag);

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      divider              <= DIVIDER_RESET;
      divider_low_shadow   <= DIVIDER_RESET[7:0];
      receiver_enable      <= 1'b0;
      word_nine            <= 1'b0;
      receive_irq_enable   <= 1'b0;
      idle_line_irq_enable <= 1'b0;
      two_stop             <= 1'b0;
    end
    else if (clk_en_i)
    begin
      // Low half waits for high-half write, as software orders them
      if (wr_to(DIVIDER_LOW_REGISTER_ADDR))
        divider_low_shadow <= avs_writedata_i[7:0];
      if (wr_to(DIVIDER_HIGH_REGISTER_ADDR))
        divider <= {avs_writedata_i[7:0], divider_low_shadow};
      if (wr_to(FLAG_REGISTER_ADDR) && avs_byteenable_i[1])
      begin
        receiver_enable      <= avs_writedata_i[8 + CTL_RX_ENABLE_BIT];
        word_nine            <= avs_writedata_i[8 + CTL_WORD9_BIT];
        receive_irq_enable   <= avs_writedata_i[8 + CTL_RX_IRQ_EN_BIT];
        idle_line_irq_enable <= avs_writedata_i[8 + CTL_IDLE_IRQ_EN_BIT];
        two_stop             <= avs_writedata_i[8 + CTL_TWO_STOP_BIT];
      end
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (clk_en_i && acc && avs_read_i)
    begin
      unique case (avs_address_i)
        FLAG_REGISTER_ADDR:
          avs_readdata_o <= {15'h0000, ninth_received_bit,
                             3'b000, two_stop, idle_line_irq_enable,
                             receive_irq_enable, word_nine,
                             receiver_enable,
                             2'b00, receive_full_flag, idle_flag,
                             overrun_flag, noise_flag, framing_flag, 1'b0};
        DATA_PORT_REGISTER_ADDR:
          avs_readdata_o <= {24'h000000, receive_holding_buffer};
        DIVIDER_HIGH_REGISTER_ADDR:
          avs_readdata_o <= {24'h000000, divider[15:8]};
        DIVIDER_LOW_REGISTER_ADDR:
          avs_readdata_o <= {24'h000000, divider[7:0]};
        default:
          avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule : uar_receiver

// [uar_receiver_assertions.sv]
`timescale 1ns/1ps
module uar_receiver_assertions
  import uar_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        clk_en_i,
  // Serial line
  input wire logic        rx_line_i,
  // Register bus
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Interrupt
  input wire logic        rx_irq_o
);
  // ********
  // Interrupt enable shadow
  // ********
  logic irq_en;

  // Tracks every cycle of a control write, so it may lead the register
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
    if (sys_rst_i)
      irq_en <= 1'b0;
    else if (clk_en_i && avs_write_i && avs_address_i == FLAG_REGISTER_ADDR
             && avs_byteenable_i[1:0] == 2'b11)
      irq_en <= avs_writedata_i[8+CTL_RX_IRQ_EN_BIT]
                | avs_writedata_i[8+CTL_IDLE_IRQ_EN_BIT];

  // ********
  // Properties
  // ********
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_taken;
    (avs_read_i || avs_write_i) && avs_waitrequest_o && clk_en_i;
  endsequence
  sequence s_answer;
    !avs_waitrequest_o;
  endsequence

  a_one_wait: assert property (s_taken ##1 clk_en_i |-> s_answer)
    else $error("bus answer missing one cycle after request");
  a_wait_first: assert property ($rose(avs_read_i || avs_write_i)
    |-> avs_waitrequest_o)
    else $error("new request answered without a wait state");
  a_idle_nowait: assert property (!avs_read_i && !avs_write_i
    |-> !avs_waitrequest_o)
    else $error("wait request raised with no request");
  a_reset_quiet: assert property ($fell(sys_rst_i)
    |-> !rx_irq_o && avs_readdata_o == 32'h0)
    else $error("outputs not quiet after reset");
  a_irq_enabled: assert property (
    rx_irq_o |-> irq_en || $past(irq_en))
    else $error("interrupt raised with enables off");
  a_full_irq: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i == FLAG_REGISTER_ADDR
    && avs_readdata_o[8+CTL_RX_IRQ_EN_BIT]
    && (avs_readdata_o[FLG_FULL_BIT] || avs_readdata_o[FLG_OVERRUN_BIT])
    |-> rx_irq_o)
    else $error("full or overrun shown without interrupt");
  a_data_held: assert property (
    $changed(avs_readdata_o) |-> $past(avs_read_i && avs_waitrequest_o))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
    && avs_address_i[1:0] != 2'b00 |-> avs_readdata_o == 32'h0)
    else $error("unmapped read returned nonzero");
endmodule : uar_receiver_assertions

bind uar_receiver uar_receiver_assertions u_chk (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
  .rx_line_i(rx_line_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .rx_irq_o(rx_irq_o)
);

// [uar_tx_model.sv]
`timescale 1ns/1ps
module uar_tx_model #(
  parameter int BIT_CLKS = 16
)(
  input  wire logic core_clk_i,
  output logic      rx_line_o
);
  // Line idles at mark between frames
  initial rx_line_o = 1'b1;

  // Low pulse too short to pass the start check
  task automatic pulse(input int n);
    repeat (n) @(posedge core_clk_i) rx_line_o <= 1'b0;
    @(posedge core_clk_i) rx_line_o <= 1'b1;
  endtask : pulse

  // One glitch clock lands inside the three-sample window of bit 0
  task automatic send(input logic [8:0] data, input int nbits,
                      input logic stop_lvl, input logic glitch);
    logic lvl;
    for (int i = 0; i <= nbits + 1; i++)
    begin
      lvl = (i == 0) ? 1'b0 : (i > nbits) ? stop_lvl : data[i-1];
      for (int k = 0; k < BIT_CLKS; k++)
        @(posedge core_clk_i) rx_line_o <= (glitch && i == 1 && k == 9)
                                           ? ~lvl : lvl;
    end
    repeat (4) @(posedge core_clk_i) rx_line_o <= 1'b1;
  endtask : send
endmodule : uar_tx_model

// [uar_receiver_bench.sv]
`timescale 1ns/1ps
module uar_receiver_bench;
  import uar_pkg::*;
  // ********
  // Expected register images
  // ********
  localparam logic [31:0] CTL = 32'h0000_0500;
  localparam logic [31:0] W9  = 32'h0000_0200;
  localparam logic [31:0] FRM = 32'h0000_0002;
  localparam logic [31:0] NOI = 32'h0000_0004;
  localparam logic [31:0] OVR = 32'h0000_0008;
  localparam logic [31:0] IDL = 32'h0000_0010;
  localparam logic [31:0] FUL = 32'h0000_0020;
  localparam logic [31:0] R9  = 32'h0001_0000;

  logic        core_clk_i;
  logic        sys_rst_i;
  logic        clk_en_i;
  logic        rx_line;
  logic [3:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        rx_irq_o;
  logic [31:0] rd_val;
  int          n_fail;
  int          compares;
  logic [8:0]  f_data [4] = '{9'h0A5, 9'h081, 9'h000, 9'h001};
  logic        f_stop [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic        f_nz   [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  logic [31:0] f_flag [4] = '{FUL, FUL | FRM, FUL | FRM, FUL | NOI};

  uar_receiver dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .rx_line_i(rx_line), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .rx_irq_o(rx_irq_o)
  );
  uar_tx_model tx (.core_clk_i(core_clk_i), .rx_line_o(rx_line));

  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  // ********
  // Bus and check tasks
  // ********
  task automatic stop_test;
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge core_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= wd;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 20);
    rd_val = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 20)
    begin
      n_fail++;
      stop_test();
    end
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input string what);
    bus(1'b0, a, 32'h0);
    chk(what, e, rd_val);
  endtask : rd

  // Flag read then data read empties every flag before a new frame
  task automatic flush;
    bus(1'b0, 4'h0, 32'h0);
    bus(1'b0, 4'h4, 32'h0);
  endtask : flush

  // ********
  // Main sequence
  // ********
  initial
  begin
    n_fail = 0;
    compares = 0;
    sys_rst_i = 1'b1;
    clk_en_i = 1'b1;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    repeat (20) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rd(4'h0, 32'h0, "reset image");
    wr(4'h2, 32'hFFFF_FFFF);
    rd(4'h2, 32'h0, "unmapped");
    wr(4'h0, 32'h0);
    wr(4'hC, 32'h10);
    wr(4'h8, 32'h00);
    wr(4'h0, CTL);
    for (int i = 0; i < 4; i++)
    begin
      flush();
      tx.send(f_data[i], 8, f_stop[i], f_nz[i]);
      chk("irq set", 32'h1, {31'h0, rx_irq_o});
      rd(4'h0, CTL | f_flag[i], "flags");
      rd(4'h4, {24'h0, f_data[i][7:0]}, "data");
      rd(4'h0, CTL, "flags cleared");
      chk("irq clear", 32'h0, {31'h0, rx_irq_o});
    end
    // Second frame lands while full on purpose
    flush();
    tx.send(9'h03C, 8, 1'b1, 1'b0);
    tx.send(9'h05A, 8, 1'b1, 1'b0);
    chk("irq overrun", 32'h1, {31'h0, rx_irq_o});
    rd(4'h0, CTL | FUL | OVR, "overrun");
    rd(4'h4, 32'h3C, "kept data");
    rd(4'h0, CTL, "overrun cleared");
    tx.send(9'h033, 8, 1'b1, 1'b0);
    wr(4'h0, CTL);
    rd(4'h0, CTL, "zero write");
    tx.pulse(2);
    repeat (40) @(posedge core_clk_i);
    rd(4'h0, CTL, "false start");
    fork
      tx.send(9'h055, 8, 1'b1, 1'b0);
      begin
        repeat (60) @(posedge core_clk_i);
        wr(4'h0, 32'h0000_0400);
      end
    join
    wr(4'h0, CTL);
    rd(4'h0, CTL, "aborted frame");
    wr(4'h0, CTL | W9);
    tx.send(9'h1AB, 9, 1'b1, 1'b0);
    rd(4'h0, CTL | W9 | FUL | R9, "ninth bit");
    rd(4'h4, 32'hAB, "nine bit data");
    repeat (200) @(posedge core_clk_i);
    rd(4'h0, CTL | W9 | R9 | FUL | IDL, "idle frame");
    stop_test();
  end
endmodule : uar_receiver_bench
